// ---- dv/hpra_monitor.sv ----
// Port checker for the PHY register access block
module hpra_monitor (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        phy_req_r,
    input logic        phy_we_r,
    input logic [4:0]  phy_dev_r,
    input logic [4:0]  phy_idx_r,
    input logic [15:0] phy_wdata_r,
    input logic        phy_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Bus and PHY port properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_req_wait;
        phy_req_r && !phy_ack;
    endsequence
    sequence s_req_done;
        phy_req_r && phy_ack;
    endsequence
    a_req_holds: assert property (s_req_wait |=> phy_req_r)
        else $error("request dropped before ack");
    a_req_ends: assert property (s_req_done |=> !phy_req_r[*4])
        else $error("request not ended after ack");
    a_fields_stable: assert property (s_req_wait |=>
        $stable({phy_we_r, phy_dev_r, phy_idx_r, phy_wdata_r}))
        else $error("request fields changed");
    a_wr_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing wrong");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read response timing wrong");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response changed");
    a_no_early_req: assert property ($rose(phy_req_r) |-> !$past(phy_ack))
        else $error("request raised at ack");
endmodule // hpra_monitor

// ---- dv/hpra_phy_model.sv ----
// Behavioural PHY register set answering the request port
module hpra_phy_model (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic        phy_req_r,
    input  logic        phy_we_r,
    input  logic [4:0]  phy_dev_r,
    input  logic [4:0]  phy_idx_r,
    input  logic [15:0] phy_wdata_r,
    input  logic [7:0]  lat,
    output logic        phy_ack,
    output logic [15:0] phy_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:1023];
    logic [7:0]  cnt;
    // Ack lat+1 cycles after the request rises; read data only valid in the ack cycle
    always @(posedge aclk) begin
        phy_ack   <= 1'b0;
        phy_rdata <= ~phy_rdata;
        cnt       <= 8'h00;
        if (!aresetn) begin
            phy_rdata <= 16'h5A5A;
        end else if (phy_req_r && !phy_ack) begin
            cnt <= cnt + 8'h01;
            if (cnt == lat) begin
                phy_ack <= 1'b1;
                cnt     <= 8'h00;
                if (phy_we_r)
                    mem[{phy_dev_r, phy_idx_r}] <= phy_wdata_r;
                else
                    phy_rdata <= mem[{phy_dev_r, phy_idx_r}];
            end
        end
    end
endmodule // hpra_phy_model

// ---- dv/hpra_top_tb.sv ----
// Self-checking bench for the PHY register access block
`include "hpra_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module hpra_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, phy_req_r, phy_we_r, phy_ack;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [4:0]  phy_dev_r, phy_idx_r, dv, ix;
    logic [15:0] phy_wdata_r, phy_rdata, dt;
    logic        w;
    logic [34:0] rows [4] = '{{1'b1, 5'h1F, 5'h00, 16'hA55A, 8'h00},
        {1'b1, 5'h00, 5'h1F, 16'h0001, 8'h05},
        {1'b0, 5'h1F, 5'h00, 16'hA55A, 8'h02},
        {1'b0, 5'h00, 5'h1F, 16'h0001, 8'h00}};
    int err_count = 0, checks = 0;
    hpra_top u_hpra_top (.*);
    hpra_phy_model u_hpra_phy_model (.*);
    // Clock generation
    always #5 aclk = ~aclk;
    // One AXI write, both channels offered together
    task automatic wr(input [7:0] a, input [31:0] v, output [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            // Response accepted one cycle after it shows
            if (s_axi_bvalid === 1'b1 && !s_axi_bready)
                s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            && n < 99);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 99) err_count++;
    endtask
    // One AXI read
    task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            // Data accepted one cycle after it shows
            if (s_axi_rvalid === 1'b1 && !s_axi_rready)
                s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            && n < 99);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 99) err_count++;
    endtask
    // Wait for the busy bit to clear
    task automatic poll();
        int n;
        n = 0;
        do begin
            rd(`HPRA_ADDR_ACC_CTRL, d, r);
            n++;
        end while (d[0] !== 1'b0 && n < 80);
        if (n >= 80) err_count++;
    endtask
    task automatic give_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`HPRA_ADDR_ACC_CTRL, d, r);
        `CHK(d, 32'h0)
        rd(`HPRA_ADDR_DATA, d, r);
        `CHK(d, 32'h0)
        // Table rows: writes first, then reads of the same registers
        for (int i = 0; i < 4; i++) begin
            {w, dv, ix, dt} = rows[i][34:8];
            lat <= rows[i][7:0];
            if (w) wr(`HPRA_ADDR_DATA, {16'h0, dt}, r);
            wr(`HPRA_ADDR_ACC_CTRL,
                {16'h0, dv, ix, 4'h0, w, 1'b1}, r);
            `CHK(r, `HPRA_RESP_OKAY)
            poll();
            rd(`HPRA_ADDR_DATA, d, r);
            `CHK(d, {16'h0, dt})
            rd(`HPRA_ADDR_ACC_CTRL, d, r);
            `CHK(d, {16'h0, dv, ix, 4'h0, w, 1'b0})
        end
        // Slow read: busy visible, both registers refused meanwhile
        lat <= 8'h28;
        wr(`HPRA_ADDR_ACC_CTRL, {16'h0, 5'h1F, 5'h00, 6'h01}, r);
        rd(`HPRA_ADDR_ACC_CTRL, d, r);
        `CHK(d[0], 1'b1)
        wr(`HPRA_ADDR_DATA, 32'h1234, r);
        `CHK(r, `HPRA_RESP_SLVERR)
        wr(`HPRA_ADDR_ACC_CTRL, 32'h0, r);
        `CHK(r, `HPRA_RESP_SLVERR)
        poll();
        `CHK(d, 32'h0000_F800)
        rd(`HPRA_ADDR_DATA, d, r);
        `CHK(d, 32'hA55A)
        // Bit 0 low starts nothing; reserved bits read zero
        wr(`HPRA_ADDR_ACC_CTRL, 32'hFFFF_FFFE, r);
        rd(`HPRA_ADDR_ACC_CTRL, d, r);
        `CHK(d, 32'h0000_FFC2)
        `CHK(phy_req_r, 1'b0)
        wr(`HPRA_ADDR_DATA, 32'hFFFF_0000, r);
        rd(`HPRA_ADDR_DATA, d, r);
        `CHK(d, 32'h0)
        // Single byte lane lands, the others keep their value
        s_axi_wstrb <= 4'h2;
        wr(`HPRA_ADDR_DATA, 32'h1234_AB55, r);
        s_axi_wstrb <= 4'hF;
        rd(`HPRA_ADDR_DATA, d, r);
        `CHK(d, 32'h0000_AB00)
        rd(8'h20, d, r);
        `CHK(r, `HPRA_RESP_SLVERR)
        // Mid-run reset returns both registers to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`HPRA_ADDR_ACC_CTRL, d, r);
        `CHK(d, 32'h0)
        rd(`HPRA_ADDR_DATA, d, r);
        `CHK(d, 32'h0)
        give_verdict();
    end
endmodule // hpra_top_tb
bind hpra_top hpra_monitor u_hpra_monitor (.*);

// ---- rtl/hpra_phy_port.v ----
// Sequencer driving one access onto the internal PHY register port
module hpra_phy_port (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        start,
    input  wire        wnr,
    input  wire [4:0]  dev_sel,
    input  wire [4:0]  reg_idx,
    input  wire [15:0] wdata,
    output reg         phy_req_r,
    output reg         phy_we_r,
    output reg  [4:0]  phy_dev_r,
    output reg  [4:0]  phy_idx_r,
    output reg  [15:0] phy_wdata_r,
    input  wire        phy_ack,
    input  wire [15:0] phy_rdata,
    output reg         done_r,
    output reg         done_rd_r,
    output reg  [15:0] rdata_r
);

    // ******************************
    // Request and completion
    // ******************************
    // Request stands until the register set acknowledges it
    always @(posedge aclk) begin
        if (!aresetn) begin
            phy_req_r   <= 1'b0;
            phy_we_r    <= 1'b0;
            phy_dev_r   <= 5'h00;
            phy_idx_r   <= 5'h00;
            phy_wdata_r <= 16'h0000;
            done_r      <= 1'b0;
            done_rd_r   <= 1'b0;
            rdata_r     <= 16'h0000;
        end else begin
            done_r    <= 1'b0;
            done_rd_r <= 1'b0;
            if (start && !phy_req_r) begin
                phy_req_r   <= 1'b1;
                phy_we_r    <= wnr;
                phy_dev_r   <= dev_sel;
                phy_idx_r   <= reg_idx;
                phy_wdata_r <= wdata;
            end else if (phy_req_r && phy_ack) begin
                phy_req_r <= 1'b0;
                done_r    <= 1'b1;
                done_rd_r <= !phy_we_r;
                rdata_r   <= phy_rdata; // Captured with done
            end
        end
    end

endmodule // hpra_phy_port

// ---- rtl/hpra_top.v ----
// AXI4-Lite register front end for host access to internal PHY registers
// Notes on behaviour
// - Bits 10:6 pick the register inside the target device, reset 0.
// - Bit 1 high writes the data register out, low reads into it.
// - Bit 0 stays high for the whole access and clears itself at the end.
// - Read data is only valid once bit 0 has cleared.
// - The data register holds the 16-bit value in bits 15:0, reset 0.
`include "hpra_map.vh"

module hpra_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         phy_req_r,
    output reg         phy_we_r,
    output reg  [4:0]  phy_dev_r,
    output reg  [4:0]  phy_idx_r,
    output reg  [15:0] phy_wdata_r,
    input  wire        phy_ack,
    input  wire [15:0] phy_rdata
);

    // ******************************
    // Register state
    // ******************************
    reg  [4:0]  target_device_select_r;
    reg  [4:0]  target_register_index_r;
    reg         write_not_read_r;
    reg         access_in_progress_r;
    reg  [15:0] phy_mgmt_data_r;
    reg  [7:0]  aw_addr_r;
    reg         aw_have_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         w_have_r;
    reg         start_r;

    wire        done;
    wire        done_rd;
    wire [15:0] rdata_phy;
    wire        req_o;
    wire        we_o;
    wire [4:0]  dev_o;
    wire [4:0]  idx_o;
    wire [15:0] wd_o;

    wire        wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

    // Merge byte lanes of a write onto an old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Control register as read back, reserved bits zero
    function [31:0] ctrl_word;
        input [4:0] dev;
        input [4:0] idx;
        input       wnr;
        input       busy;
        begin
            ctrl_word = 32'h0000_0000;
            ctrl_word[`HPRA_DEV_HI:`HPRA_DEV_LO] = dev;
            ctrl_word[`HPRA_IDX_HI:`HPRA_IDX_LO] = idx;
            ctrl_word[`HPRA_WNR_BIT]  = wnr;
            ctrl_word[`HPRA_BUSY_BIT] = busy;
        end
    endfunction

    wire [31:0] ctrl_new = merge(ctrl_word(target_device_select_r,
        target_register_index_r, write_not_read_r, access_in_progress_r),
        w_data_r, w_strb_r);
    wire [31:0] data_new = merge({16'h0000, phy_mgmt_data_r},
        w_data_r, w_strb_r);

    // ******************************
    // Write address and data capture
    // ******************************
    // Either channel may arrive first; each held until the response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_have_r     <= 1'b0;
                w_have_r      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ******************************
    // Register update and response
    // ******************************
    // Writes while busy are dropped and answered with an error
    always @(posedge aclk) begin
        if (!aresetn) begin
            target_device_select_r  <= `HPRA_RST_FIELD5;
            target_register_index_r <= `HPRA_RST_FIELD5;
            write_not_read_r        <= 1'b0;
            access_in_progress_r    <= 1'b0;
            phy_mgmt_data_r         <= `HPRA_RST_DATA;
            start_r                 <= 1'b0;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= `HPRA_RESP_OKAY;
        end else begin
            start_r <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Completion clears busy; read data loaded same edge
            if (done) begin
                access_in_progress_r <= 1'b0;
                if (done_rd)
                    phy_mgmt_data_r <= rdata_phy;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `HPRA_RESP_OKAY;
                if (access_in_progress_r &&
                    (aw_addr_r == `HPRA_ADDR_ACC_CTRL ||
                     aw_addr_r == `HPRA_ADDR_DATA)) begin
                    s_axi_bresp <= `HPRA_RESP_SLVERR;
                end else if (aw_addr_r == `HPRA_ADDR_ACC_CTRL) begin
                    target_device_select_r  <=
                        ctrl_new[`HPRA_DEV_HI:`HPRA_DEV_LO];
                    target_register_index_r <=
                        ctrl_new[`HPRA_IDX_HI:`HPRA_IDX_LO];
                    write_not_read_r <= ctrl_new[`HPRA_WNR_BIT];
                    if (ctrl_new[`HPRA_BUSY_BIT]) begin
                        access_in_progress_r <= 1'b1;
                        start_r              <= 1'b1;
                    end
                end else if (aw_addr_r == `HPRA_ADDR_DATA) begin
                    phy_mgmt_data_r <= data_new[15:0];
                end else begin
                    s_axi_bresp <= `HPRA_RESP_SLVERR;
                end
            end
        end
    end

    // ******************************
    // Read channel
    // ******************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `HPRA_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `HPRA_RESP_OKAY;
            case (s_axi_araddr)
                `HPRA_ADDR_ACC_CTRL:
                    s_axi_rdata <= ctrl_word(target_device_select_r,
                        target_register_index_r, write_not_read_r,
                        access_in_progress_r);
                `HPRA_ADDR_DATA:
                    s_axi_rdata <= {16'h0000, phy_mgmt_data_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `HPRA_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ******************************
    // PHY port sequencer
    // ******************************
    hpra_phy_port u_port (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (start_r),
        .wnr         (write_not_read_r),
        .dev_sel     (target_device_select_r),
        .reg_idx     (target_register_index_r),
        .wdata       (phy_mgmt_data_r),
        .phy_req_r   (req_o),
        .phy_we_r    (we_o),
        .phy_dev_r   (dev_o),
        .phy_idx_r   (idx_o),
        .phy_wdata_r (wd_o),
        .phy_ack     (phy_ack),
        .phy_rdata   (phy_rdata),
        .done_r      (done),
        .done_rd_r   (done_rd),
        .rdata_r     (rdata_phy)
    );

    // Output copies registered in the top
    always @(posedge aclk) begin
        if (!aresetn) begin
            phy_req_r   <= 1'b0;
            phy_we_r    <= 1'b0;
            phy_dev_r   <= 5'h00;
            phy_idx_r   <= 5'h00;
            phy_wdata_r <= 16'h0000;
        end else begin
            phy_req_r   <= req_o & ~(phy_req_r & phy_ack);
            phy_we_r    <= we_o;
            phy_dev_r   <= dev_o;
            phy_idx_r   <= idx_o;
            phy_wdata_r <= wd_o;
        end
    end

endmodule // hpra_top

// ---- shared/hpra_map.vh ----
// Register offsets, field positions and reset values of the PHY access block
`ifndef HPRA_MAP_VH
`define HPRA_MAP_VH

// Printed register indices (byte address is four times the index)
`define HPRA_IDX_ACC_CTRL      4'h6
`define HPRA_IDX_DATA          4'h7
`define HPRA_ADDR_ACC_CTRL     {2'h0, `HPRA_IDX_ACC_CTRL, 2'h0}
`define HPRA_ADDR_DATA         {2'h0, `HPRA_IDX_DATA, 2'h0}

// Access control fields
`define HPRA_DEV_HI            15
`define HPRA_DEV_LO            11
`define HPRA_IDX_HI            10
`define HPRA_IDX_LO            6
`define HPRA_WNR_BIT           1
`define HPRA_BUSY_BIT          0

// Reset values
`define HPRA_RST_FIELD5        5'h00
`define HPRA_RST_DATA          16'h0000

// Response codes
`define HPRA_RESP_OKAY         2'h0
`define HPRA_RESP_SLVERR       2'h2

`endif
